/* File: hw/tw_master_tx.sv */
// Two-wire master transmitter: APB registers and the transfer sequencer.
// Assumes an APB master on pclk and pull-ups on both open-drain lines.
`timescale 1ns/1ns
module tw_master_tx (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n
);
  typedef enum logic [1:0] {T_IDLE, T_WAIT, T_BUSY, T_HOLD} tw_state_e;

  tw_state_e       state_r;
  tw_state_e       state_nxt;
  tw_pkg::tw_cmd_e kind_r;
  tw_pkg::tw_cmd_e kind_nxt;
  logic [7:0]      code_r;
  logic [7:0]      code_nxt;
  logic [7:0]      data_r;
  logic            go_r;
  logic            go_nxt;
  logic            owns_r;
  logic            owns_nxt;
  logic            rx_r;
  logic            rx_nxt;
  logic            addr_r;
  logic            addr_nxt;
  logic            rsta_r;
  logic            rsta_nxt;
  logic            chain_r;
  logic            chain_nxt;
  logic            stop_clr;
  logic            ack_en_r;
  logic            start_req_r;
  logic            stop_req_r;
  logic            wcol_r;
  logic            en_r;
  logic            irq_en_r;
  logic            busy_r;
  logic            scl_p_r;
  logic            sda_p_r;
  logic            low_r;
  logic [1:0]      pins_s;
  logic            e_done;
  logic            e_nack;
  logic            e_arb;

  // Line inputs come from the bus pins
  tw_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_in, sda_in}),
    .q     (pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];

  tw_bitline u_bit (
    .clk      (pclk),
    .rst_n    (presetn),
    .go       (go_r),
    .kind     (kind_r),
    .tx_byte  (data_r),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .done     (e_done),
    .nack     (e_nack),
    .arb      (e_arb),
    .scl_oe_n (scl_oe_n),
    .sda_oe_n (sda_oe_n)
  );

  // Bus activity seen on the lines, our own included
  wire seen_start = scl_s && scl_p_r && sda_p_r && !sda_s;
  wire seen_stop  = scl_s && scl_p_r && !sda_p_r && sda_s;

  // APB decode; no wait states, data fetched in the setup cycle
  wire setup    = psel && !penable;
  wire acc      = psel && penable && pready;
  wire wr       = acc && pwrite;
  wire hit_ctl  = (paddr == tw_pkg::OFS_CTRL);
  wire hit_stat = (paddr == tw_pkg::OFS_STAT);
  wire hit_data = (paddr == tw_pkg::OFS_DATA);
  wire mapped   = hit_ctl || hit_stat || hit_data;
  wire ctl_wr   = wr && hit_ctl;
  wire data_wr  = wr && hit_data;

  // Done flag is the hold state itself
  wire hold = (state_r == T_HOLD);

  wire [7:0] ctl_rd = {hold, ack_en_r, start_req_r, stop_req_r,
                       wcol_r, en_r, 1'b0, irq_en_r};
  wire [7:0] stat_rd = {code_r[7:3], 3'h0};
  wire [7:0] rd_byte = hit_ctl  ? ctl_rd :
                       hit_stat ? stat_rd :
                       hit_data ? data_r : 8'h00;

  // Written control bits that steer the sequencer
  wire w_done  = pwdata[tw_pkg::CTL_DONE];
  wire w_start = pwdata[tw_pkg::CTL_START];
  wire w_stop  = pwdata[tw_pkg::CTL_STOP];
  wire w_en    = pwdata[tw_pkg::CTL_EN];
  wire idle    = (state_r == T_IDLE);
  wire trig    = ctl_wr && w_done && w_en && (idle || hold);
  wire at_addr = (code_r == tw_pkg::CODE_START) ||
                 (code_r == tw_pkg::CODE_RSTART);

  // Sequencer: decides the next bus action and the status it posts
  always_comb begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    code_nxt  = code_r;
    go_nxt    = 1'b0;
    owns_nxt  = owns_r;
    rx_nxt    = rx_r;
    addr_nxt  = addr_r;
    rsta_nxt  = rsta_r;
    chain_nxt = chain_r;
    stop_clr  = 1'b0;
    case (state_r)
      T_IDLE: begin
        if (trig && w_start) begin
          state_nxt = T_WAIT;
          rsta_nxt  = 1'b0;
        end
      end
      T_WAIT: begin
        // Start only on a free bus
        if (!busy_r) begin
          state_nxt = T_BUSY;
          go_nxt    = 1'b1;
          kind_nxt  = tw_pkg::CMD_START;
        end
      end
      T_HOLD: begin
        if (trig) begin
          if (!owns_r) begin
            // After lost arbitration nothing is held
            state_nxt = w_start ? T_WAIT : T_IDLE;
            rsta_nxt  = 1'b0;
          end else if (w_stop) begin
            state_nxt = T_BUSY;
            go_nxt    = 1'b1;
            kind_nxt  = tw_pkg::CMD_STOP;
            chain_nxt = w_start;
          end else if (w_start) begin
            state_nxt = T_BUSY;
            go_nxt    = 1'b1;
            kind_nxt  = tw_pkg::CMD_START;
            rsta_nxt  = 1'b1;
          end else if (at_addr || !rx_r) begin
            state_nxt = T_BUSY;
            go_nxt    = 1'b1;
            kind_nxt  = tw_pkg::CMD_BYTE;
            addr_nxt  = at_addr;
            if (at_addr) begin
              rx_nxt = data_r[0];
            end
          end
        end
      end
      T_BUSY: begin
        if (e_done) begin
          case (kind_r)
            tw_pkg::CMD_START: begin
              state_nxt = T_HOLD;
              owns_nxt  = 1'b1;
              code_nxt  = rsta_r ? tw_pkg::CODE_RSTART : tw_pkg::CODE_START;
            end
            tw_pkg::CMD_STOP: begin
              owns_nxt  = 1'b0;
              stop_clr  = 1'b1;
              chain_nxt = 1'b0;
              rsta_nxt  = 1'b0;
              if (chain_r) begin
                state_nxt = T_WAIT;
              end else begin
                state_nxt = T_IDLE;
                code_nxt  = tw_pkg::CODE_NONE;
              end
            end
            default: begin
              state_nxt = T_HOLD;
              if (e_arb) begin
                owns_nxt = 1'b0;
                code_nxt = tw_pkg::CODE_ARB;
              end else if (addr_r && rx_r) begin
                code_nxt = e_nack ? tw_pkg::CODE_AR_NACK : tw_pkg::CODE_AR_ACK;
              end else if (addr_r) begin
                code_nxt = e_nack ? tw_pkg::CODE_AW_NACK : tw_pkg::CODE_AW_ACK;
              end else begin
                code_nxt = e_nack ? tw_pkg::CODE_D_NACK : tw_pkg::CODE_D_ACK;
              end
            end
          endcase
        end
      end
      default: begin
        state_nxt = T_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= T_IDLE;
      kind_r  <= tw_pkg::CMD_START;
      code_r  <= tw_pkg::CODE_NONE;
      go_r    <= 1'b0;
      owns_r  <= 1'b0;
      rx_r    <= 1'b0;
      addr_r  <= 1'b0;
      rsta_r  <= 1'b0;
      chain_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      code_r  <= code_nxt;
      go_r    <= go_nxt;
      owns_r  <= owns_nxt;
      rx_r    <= rx_nxt;
      addr_r  <= addr_nxt;
      rsta_r  <= rsta_nxt;
      chain_r <= chain_nxt;
    end
  end

  // Bus-busy tracker fed from the line monitor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
      if (seen_start) begin
        busy_r <= 1'b1;
      end else if (seen_stop) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Control bits; hardware clears the stop request after its STOP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_en_r    <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r  <= 1'b0;
      en_r        <= 1'b0;
      irq_en_r    <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ack_en_r    <= pwdata[tw_pkg::CTL_ACKEN];
        start_req_r <= w_start;
        en_r        <= w_en;
        irq_en_r    <= pwdata[tw_pkg::CTL_IRQEN];
      end
      if (stop_clr) begin
        stop_req_r <= 1'b0;
      end else if (ctl_wr) begin
        stop_req_r <= w_stop;
      end
    end
  end

  // Data register accepts bytes only while the flag is up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= tw_pkg::DATA_RST;
      wcol_r <= 1'b0;
    end else if (data_wr) begin
      if (hold) begin
        data_r <= pwdata[7:0];
        wcol_r <= 1'b0;
      end else begin
        wcol_r <= 1'b1;
      end
    end
  end

  // APB answer flops; the line outputs only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      low_r   <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      low_r   <= 1'b0;
      if (setup && !pwrite) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign scl_out = low_r;
  assign sda_out = low_r;
endmodule

/* File: hw/tw_pkg.sv */
// Shared constants and types of the two-wire master transmitter block.
// Assumes a 125 MHz pclk and a 100 kHz bus bit rate.
package tw_pkg;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BIT_PERIOD_NS = 10000;
  // Longest quarter of a bit, rounded down
  localparam int unsigned QTR_CYC = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [8:0]  QTR_CNT = 9'(QTR_CYC - 1);

  // Register byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;

  // Control register bit positions
  localparam int CTL_DONE  = 7;
  localparam int CTL_ACKEN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP  = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IRQEN = 0;

  // Status codes, prescaler bits zero
  localparam logic [7:0] CODE_START   = 8'h08;
  localparam logic [7:0] CODE_RSTART  = 8'h10;
  localparam logic [7:0] CODE_AW_ACK  = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_D_ACK   = 8'h28;
  localparam logic [7:0] CODE_D_NACK  = 8'h30;
  localparam logic [7:0] CODE_ARB     = 8'h38;
  localparam logic [7:0] CODE_AR_ACK  = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_NONE    = 8'hF8;

  // Data reset value and last bit index of a byte frame
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // Commands to the bit engine
  typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_BYTE} tw_cmd_e;
endpackage

/* File: hw/tw_sync.sv */
// Two-flop synchronisers for the bus line inputs, one per bit.
// Assumes inputs asynchronous to clk; only q may be read.
`timescale 1ns/1ns
module tw_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // Idle bus lines read high, so reset to one
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b1;
          q[i]      <= 1'b1;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

/* File: hw/tw_bitline.sv */
// Bit engine: START, STOP and nine-bit byte frames on the open-drain lines.
// Assumes synchronised line levels; a bit is four quarters of QTR_CNT+1.
`timescale 1ns/1ns
module tw_bitline (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            go,
  input  tw_pkg::tw_cmd_e      kind,
  input  wire logic [7:0]      tx_byte,
  input  wire logic            scl_s,
  input  wire logic            sda_s,
  output logic                 done,
  output logic                 nack,
  output logic                 arb,
  output logic                 scl_oe_n,
  output logic                 sda_oe_n
);
  tw_pkg::tw_cmd_e kind_r;
  logic        run_r;
  logic [8:0]  sh_r;
  logic [3:0]  bit_r;
  logic [1:0]  q_r;
  logic [8:0]  cnt_r;
  logic        w_sda;
  logic        w_scl;

  // Wanted line levels per quarter, one meaning released
  always_comb begin
    case (kind_r)
      tw_pkg::CMD_START: begin
        w_sda = (q_r < 2'h2);
        w_scl = (q_r == 2'h0) ? scl_oe_n : (q_r != 2'h3);
      end
      tw_pkg::CMD_STOP: begin
        w_sda = (q_r >= 2'h2);
        w_scl = (q_r != 2'h0);
      end
      default: begin
        w_sda = sh_r[8];
        w_scl = (q_r == 2'h1) || (q_r == 2'h2);
      end
    endcase
  end

  // A high quarter waits for the line, so a stretching slave is honoured
  wire is_byte = (kind_r == tw_pkg::CMD_BYTE);
  wire tick    = run_r && (cnt_r == 9'h000) && (!w_scl || scl_s);
  wire samp    = tick && is_byte && (q_r == 2'h2);
  wire lost    = samp && (bit_r != tw_pkg::BIT_LAST) && w_sda && !sda_s;
  wire fin     = tick && (q_r == 2'h3) && (!is_byte || bit_r == tw_pkg::BIT_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_r   <= tw_pkg::CMD_START;
      run_r    <= 1'b0;
      sh_r     <= 9'h1FF;
      bit_r    <= 4'h0;
      q_r      <= 2'h0;
      cnt_r    <= 9'h000;
      done     <= 1'b0;
      nack     <= 1'b0;
      arb      <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      done <= fin || lost;
      if (go && !run_r) begin
        run_r  <= 1'b1;
        kind_r <= kind;
        sh_r   <= {tx_byte, 1'b1};
        bit_r  <= 4'h0;
        q_r    <= 2'h0;
        cnt_r  <= tw_pkg::QTR_CNT;
        arb    <= 1'b0;
      end else if (lost) begin
        // Lost arbitration: let go of both lines at once
        run_r    <= 1'b0;
        arb      <= 1'b1;
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
      end else if (run_r) begin
        scl_oe_n <= w_scl;
        sda_oe_n <= w_sda;
        if (cnt_r != 9'h000) begin
          cnt_r <= cnt_r - 9'h001;
        end
        if (tick) begin
          cnt_r <= tw_pkg::QTR_CNT;
          q_r   <= q_r + 2'h1;
          if (samp && bit_r == tw_pkg::BIT_LAST) begin
            nack <= sda_s;
          end
          if (fin) begin
            run_r <= 1'b0;
          end else if (q_r == 2'h3) begin
            bit_r <= bit_r + 4'h1;
            sh_r  <= {sh_r[7:0], 1'b1};
          end
        end
      end
    end
  end
endmodule

/* File: tb/tw_master_tx_checker.sv */
// Port-level assertions for the two-wire master transmitter.
// Assumes binding into tw_master_tx; everything runs on pclk.
`timescale 1ns/1ns
module tw_master_tx_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_n,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n
);
  logic        armed_r;
  logic [10:0] quiet_r;
  logic [10:0] since_go_r;
  // Decoded bus events
  wire ctl_go   = pready && pwrite && paddr == tw_pkg::OFS_CTRL && pwdata[7] && pwdata[2];
  wire unmapped = paddr != tw_pkg::OFS_CTRL && paddr != tw_pkg::OFS_STAT
                  && paddr != tw_pkg::OFS_DATA;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Saturating counters: quiet lines and time since last go write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r    <= 1'h0;
      quiet_r    <= 11'h0;
      since_go_r <= 11'h7FF;
    end else begin
      armed_r    <= armed_r | ctl_go;
      quiet_r    <= ($changed(scl_oe_n) || $changed(sda_oe_n)) ? 11'h0
                    : quiet_r + {10'h0, quiet_r != 11'h7FF};
      since_go_r <= ctl_go ? 11'h0 : since_go_r + {10'h0, since_go_r != 11'h7FF};
    end
  end

  idle_release_a: assert property (!armed_r |-> scl_oe_n && sda_oe_n)
    else $error("lines driven before any go write");
  start_hold_a: assert property ($fell(sda_oe_n) && scl_oe_n
    |-> !sda_oe_n throughout (##[300:1000] $fell(scl_oe_n)))
    else $error("start condition not held a quarter");
  stop_free_a: assert property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n)
    |=> (sda_oe_n && scl_oe_n) [*8]) else $error("bus not free after stop");
  edge_apart_a: assert property ($fell(scl_oe_n) |-> $stable(sda_oe_n))
    else $error("data line moved with clock fall");
  stall_hold_a: assert property (quiet_r > 11'd1300
    && ($changed(scl_oe_n) || $changed(sda_oe_n)) |-> since_go_r < 11'd1000)
    else $error("stalled transfer moved without go");
  drive_low_a: assert property (!scl_out && !sda_out)
    else $error("open-drain drive value not low");
  status_low_a: assert property (pready && !pwrite && paddr == tw_pkg::OFS_STAT
    |-> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0) else $error("status low bits set");
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access pulse");
  err_decode_a: assert property (pready
    |-> pslverr == unmapped && (!unmapped || pwrite || prdata == 32'h0))
    else $error("pslverr or unmapped read data wrong");

  cover property ($fell(sda_oe_n) && scl_oe_n);
  cover property ($rose(sda_oe_n) && scl_oe_n && $past(scl_oe_n));
  cover property (pready && pslverr);
endmodule

bind tw_master_tx tw_master_tx_checker i_tw_master_tx_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n));

/* File: tb/tw_slave_model.sv */
// Receiver-only slave on the two-wire bus, behavioural.
// Assumes pulled-up lines; acknowledges one address, either direction, and all data.
`timescale 1ns/1ns
module tw_slave_model #(
  parameter logic [7:0] ADDR_W = 8'hA0
) (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull_n,
  output logic [7:0]      last_byte,
  output int              stops
);
  logic [7:0] sh;
  int         cnt;
  logic       first;
  logic       ackph;
  logic       busy;

  initial begin
    sda_pull_n = 1'h1;
    last_byte  = 8'h00;
    stops      = 0;
    cnt        = 0;
    first      = 1'h0;
    ackph      = 1'h0;
    busy       = 1'h0;
    sh         = 8'h00;
  end
  // Start and stop seen as data edges with clock high
  always @(negedge sda) if (scl === 1'h1) begin
    cnt   = 0;
    first = 1'h1;
    ackph = 1'h0;
    busy  = 1'h1;
  end
  // Busy guard keeps time-zero edges from counting as stops
  always @(posedge sda) if (scl === 1'h1 && busy) begin
    stops++;
    cnt  = 0;
    busy = 1'h0;
  end
  // Bits taken MSB first on the rising clock
  always @(posedge scl) if (!ackph && cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt++;
  end
  // Acknowledge driven low for one bit, then released
  always @(negedge scl) begin
    if (ackph) begin
      sda_pull_n = 1'h1;
      ackph      = 1'h0;
      cnt        = 0;
      first      = 1'h0;
    end else if (cnt == 8) begin
      last_byte  = sh;
      ackph      = 1'h1;
      sda_pull_n = first && sh[7:1] != ADDR_W[7:1];
    end
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the two-wire master transmitter.
// Assumes pull-ups on both lines and one receiver model on the bus.
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic       ld;
    logic [7:0] dat;
    logic [7:0] ctl;
    logic [7:0] stat;
    logic       flag;
    logic [7:0] lastb;
    logic [1:0] nstop;
  } tw_row_s;
  // Load, data, control, status, flag, last byte seen, stops seen
  localparam tw_row_s ROWS [10] = '{
    '{1'h0, 8'h00, 8'hA4, 8'h08, 1'h1, 8'h00, 2'h0},
    '{1'h1, 8'hA0, 8'h84, 8'h18, 1'h1, 8'hA0, 2'h0},
    '{1'h1, 8'h5A, 8'h84, 8'h28, 1'h1, 8'h5A, 2'h0},
    '{1'h0, 8'h00, 8'hA4, 8'h10, 1'h1, 8'h5A, 2'h0},
    '{1'h1, 8'hB2, 8'h84, 8'h20, 1'h1, 8'hB2, 2'h0},
    '{1'h0, 8'h00, 8'hB4, 8'h08, 1'h1, 8'hB2, 2'h1},
    '{1'h1, 8'hA1, 8'h84, 8'h40, 1'h1, 8'hA1, 2'h1},
    '{1'h0, 8'h00, 8'hA4, 8'h10, 1'h1, 8'hA1, 2'h1},
    '{1'h1, 8'hB3, 8'h84, 8'h48, 1'h1, 8'hB3, 2'h1},
    '{1'h0, 8'h00, 8'h94, 8'hF8, 1'h0, 8'hB3, 2'h2}};
  localparam logic [7:0] RA [3] = '{tw_pkg::OFS_CTRL, tw_pkg::OFS_STAT, tw_pkg::OFS_DATA};
  localparam logic [7:0] RV [3] = '{8'h00, 8'hF8, 8'hFF};

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_out;
  logic        scl_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        sda_pull_n;
  logic [7:0]  last_byte;
  int          stops;
  int          miscompares;
  int          samples_checked;
  logic [31:0] q;
  logic        err;
  logic [1:0]  held;
  // Wired-AND lines with pull-ups
  wire         scl_w = scl_oe_n | scl_out;
  wire         sda_w = (sda_oe_n | sda_out) & sda_pull_n;

  tw_master_tx i_tw_master_tx (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  tw_slave_model i_tw_slave_model (.scl(scl_w), .sda(sda_w), .sda_pull_n(sda_pull_n),
    .last_byte(last_byte), .stops(stops));

  always #4 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; result left in q and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // Only pready or the watchdog ends this wait
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Polls control until the flag matches and the stop request is gone
  task automatic poll(input logic flag);
    apb(1'h0, tw_pkg::OFS_CTRL, 32'h0);
    while (q[7] !== flag || q[4] !== 1'h0) begin
      apb(1'h0, tw_pkg::OFS_CTRL, 32'h0);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    // Whole transfer: start, address, data, restarts, receive addresses, stop
    for (int i = 0; i < 10; i++) begin
      if (ROWS[i].ld) apb(1'h1, tw_pkg::OFS_DATA, {24'h0, ROWS[i].dat});
      apb(1'h1, tw_pkg::OFS_CTRL, {24'h0, ROWS[i].ctl});
      poll(ROWS[i].flag);
      apb(1'h0, tw_pkg::OFS_STAT, 32'h0);
      chk(q, {24'h0, ROWS[i].stat});
      chk({24'h0, last_byte}, {24'h0, ROWS[i].lastb});
      chk(32'(stops), {30'h0, ROWS[i].nstop});
      if (ROWS[i].flag) begin
        held = {scl_oe_n, sda_oe_n};
        apb(1'h1, tw_pkg::OFS_CTRL, 32'h04);
        repeat (1500) @(posedge pclk);
        apb(1'h0, tw_pkg::OFS_CTRL, 32'h0);
        chk({29'h0, q[7], scl_oe_n, sda_oe_n}, {29'h0, 1'h1, held});
      end
    end
    // Data write while idle is dropped and flagged
    apb(1'h1, tw_pkg::OFS_DATA, 32'h33);
    apb(1'h0, tw_pkg::OFS_CTRL, 32'h0);
    chk(q, 32'h0C);
    apb(1'h0, tw_pkg::OFS_DATA, 32'h0);
    chk(q, 32'hB3);
    apb(1'h0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    // Second reset in mid-run restores register values
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      apb(1'h0, RA[i], 32'h0);
      chk(q, {24'h0, RV[i]});
    end
    results();
  end

  // Watchdog at 95000 cycles, about a fifth beyond the expected run of some 77000
  initial begin
    #(95000 * 8);
    miscompares++;
    results();
  end
endmodule
